/* File: rtl/edw_defaults.v */
`timescale 1ns/100ps
`default_nettype none
`include "edw_map.vh"

module edw_defaults #(
    parameter TICK_DIV = `EDW_TICK_CYCLES
) (
    input  wire        clk_in,
    input  wire        reset_n_in,
    input  wire [7:0]  reg_addr_in,
    input  wire [7:0]  reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    input  wire        comm_valid_in,
    output reg  [7:0]  reg_rdata_out,
    output reg         reg_rvalid_out,
    output reg  [3:0]  work_diag_current_code_out,
    output reg  [5:0]  diag_current_num_out,
    output reg         diag_use_channel_current_out,
    output reg  [12:0] diag_pulse_us_out,
    output reg  [18:0] comm_loss_timeout_us_out,
    output reg  [15:0] init_delay_us_out,
    output reg  [7:0]  nv_short_threshold_out,
    output reg         failsafe_out,
    output reg         init_done_out,
    output reg         crc_fault_out
);
    // ------------------------------------------------------------------
    // Decode tables
    // ------------------------------------------------------------------
    function [12:0] pw_us;
        input [3:0] code;
        begin
            case (code)
                4'h0: pw_us = `EDW_PW_0;
                4'h1: pw_us = `EDW_PW_1;
                4'h2: pw_us = `EDW_PW_2;
                4'h3: pw_us = `EDW_PW_3;
                4'h4: pw_us = `EDW_PW_4;
                4'h5: pw_us = `EDW_PW_5;
                4'h6: pw_us = `EDW_PW_6;
                4'h7: pw_us = `EDW_PW_7;
                4'h8: pw_us = `EDW_PW_8;
                4'h9: pw_us = `EDW_PW_9;
                4'ha: pw_us = `EDW_PW_A;
                4'hb: pw_us = `EDW_PW_B;
                4'hc: pw_us = `EDW_PW_C;
                4'hd: pw_us = `EDW_PW_D;
                4'he: pw_us = `EDW_PW_E;
                default: pw_us = `EDW_PW_F;
            endcase
        end
    endfunction

    // Zero for disabled and for the direct codes; callers tell them apart
    function [18:0] wd_us;
        input [3:0] code;
        begin
            case (code)
                4'h1: wd_us = `EDW_WD_1;
                4'h2: wd_us = `EDW_WD_2;
                4'h3: wd_us = `EDW_WD_3;
                4'h4: wd_us = `EDW_WD_4;
                4'h5: wd_us = `EDW_WD_5;
                4'h6: wd_us = `EDW_WD_6;
                4'h7: wd_us = `EDW_WD_7;
                4'h8: wd_us = `EDW_WD_8;
                4'h9: wd_us = `EDW_WD_9;
                4'ha: wd_us = `EDW_WD_A;
                4'hb: wd_us = `EDW_WD_B;
                default: wd_us = 19'h00000;
            endcase
        end
    endfunction

    function [15:0] init_us;
        input [3:0] code;
        begin
            case (code)
                4'h0: init_us = `EDW_IN_0;
                4'h1: init_us = `EDW_IN_1;
                4'h2: init_us = `EDW_IN_2;
                4'h3: init_us = `EDW_IN_3;
                4'h4: init_us = `EDW_IN_4;
                4'h5: init_us = `EDW_IN_5;
                4'h6: init_us = `EDW_IN_6;
                4'h7: init_us = `EDW_IN_7;
                4'h8: init_us = `EDW_IN_8;
                4'h9: init_us = `EDW_IN_9;
                default: init_us = `EDW_IN_MIN;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // Stored registers
    // ------------------------------------------------------------------
    reg  [7:0]  ondemand_diag_defaults;
    reg  [7:0]  watchdog_init_timer_defaults;
    reg  [7:0]  short_threshold_default;
    reg  [7:0]  eeprom_crc_reference;
    wire [7:0]  crc_calc;
    wire [3:0]  wd_code;
    wire        wd_disabled;
    wire        wd_direct;
    wire [18:0] wd_limit;
    wire [15:0] init_limit;

    assign wd_code     = watchdog_init_timer_defaults[`EDW_WD_CODE];
    assign wd_disabled = (wd_code == `EDW_WD_OFF);
    assign wd_direct   = (wd_code > `EDW_WD_LAST_TIMED);
    assign wd_limit    = wd_us(wd_code);
    assign init_limit  = init_us(watchdog_init_timer_defaults[`EDW_INIT_CODE]);

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ondemand_diag_defaults       <= `EDW_RST_DIAG;
            watchdog_init_timer_defaults <= `EDW_RST_WDINIT;
            short_threshold_default      <= `EDW_RST_SHORT;
            eeprom_crc_reference         <= `EDW_RST_CRC;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                `EDW_OFS_DIAG:   ondemand_diag_defaults <= reg_wdata_in;
                `EDW_OFS_WDINIT: watchdog_init_timer_defaults <= reg_wdata_in;
                `EDW_OFS_SHORT:  short_threshold_default <= reg_wdata_in;
                `EDW_OFS_CRC:    eeprom_crc_reference <= reg_wdata_in;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read port: data one cycle after the strobe, unmapped reads zero
    // ------------------------------------------------------------------
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reg_rdata_out  <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    `EDW_OFS_DIAG:   reg_rdata_out <= ondemand_diag_defaults;
                    `EDW_OFS_WDINIT: reg_rdata_out <= watchdog_init_timer_defaults;
                    `EDW_OFS_SHORT:  reg_rdata_out <= short_threshold_default;
                    `EDW_OFS_CRC:    reg_rdata_out <= eeprom_crc_reference;
                    `EDW_OFS_STATUS: reg_rdata_out <= {5'h00, init_done_out,
                                                       crc_fault_out, failsafe_out};
                    default:         reg_rdata_out <= 8'h00;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Decoded defaults toward the working configuration
    // ------------------------------------------------------------------
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            work_diag_current_code_out   <= 4'h0;
            diag_current_num_out         <= 6'h01;
            diag_use_channel_current_out <= 1'b0;
            diag_pulse_us_out            <= `EDW_PW_0;
            comm_loss_timeout_us_out     <= 19'h00000;
            init_delay_us_out            <= `EDW_IN_0;
            nv_short_threshold_out       <= `EDW_RST_SHORT;
        end else begin
            work_diag_current_code_out <= ondemand_diag_defaults[`EDW_DIAG_CUR];
            // Numerator over 64 of full range; the top code never reaches it
            diag_current_num_out <= {ondemand_diag_defaults[`EDW_DIAG_CUR], 2'b01};
            diag_use_channel_current_out <=
                (ondemand_diag_defaults[`EDW_DIAG_CUR] == `EDW_CUR_CHANNEL);
            diag_pulse_us_out        <= pw_us(ondemand_diag_defaults[`EDW_DIAG_PW]);
            comm_loss_timeout_us_out <= wd_limit;
            init_delay_us_out        <= init_limit;
            nv_short_threshold_out   <= short_threshold_default;
        end
    end

    // ------------------------------------------------------------------
    // Microsecond tick divider
    // ------------------------------------------------------------------
    reg  [11:0] div_cnt;
    reg         tick;

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            div_cnt <= 12'h000;
            tick    <= 1'b0;
        end else if (div_cnt == TICK_DIV[11:0] - 12'h001) begin
            div_cnt <= 12'h000;
            tick    <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 12'h001;
            tick    <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog and fail-safe
    // ------------------------------------------------------------------
    reg  [18:0] wd_cnt;

    // Fail-safe holds until a valid host frame, and under the direct codes it stays set; no host means it stays (standalone)
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wd_cnt       <= 19'h00000;
            failsafe_out <= 1'b0;
        end else if (wd_direct) begin
            wd_cnt       <= 19'h00000;
            failsafe_out <= 1'b1;
        end else if (comm_valid_in || wd_disabled) begin
            wd_cnt <= 19'h00000;
            if (comm_valid_in)
                failsafe_out <= 1'b0;
        end else if (tick && !failsafe_out) begin
            if (wd_cnt >= wd_limit - 19'h00001)
                failsafe_out <= 1'b1;
            else
                wd_cnt <= wd_cnt + 19'h00001;
        end
    end

    // ------------------------------------------------------------------
    // Initialization timer after reset release
    // ------------------------------------------------------------------
    reg  [15:0] init_cnt;

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            init_cnt      <= 16'h0000;
            init_done_out <= 1'b0;
        end else if (!init_done_out) begin
            if (init_cnt >= init_limit)
                init_done_out <= 1'b1;
            else if (tick)
                init_cnt <= init_cnt + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // CRC check over the stored bytes, reference excluded
    // ------------------------------------------------------------------
    edw_crc8 u_crc (
        .data_in ({ondemand_diag_defaults, watchdog_init_timer_defaults,
                   short_threshold_default, 8'h00}),
        .crc_out (crc_calc)
    );

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            crc_fault_out <= 1'b0;
        else
            crc_fault_out <= (crc_calc != eeprom_crc_reference);
    end
endmodule
`default_nettype wire

/* File: rtl/edw_map.vh */
`ifndef EDW_MAP_VH
`define EDW_MAP_VH

// ----------------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------------
`define EDW_OFS_DIAG        8'hc9
`define EDW_OFS_WDINIT      8'hca
`define EDW_OFS_SHORT       8'hcb
`define EDW_OFS_CRC         8'hcf
`define EDW_OFS_STATUS      8'hd0
`define EDW_RST_DIAG        8'h00
`define EDW_RST_WDINIT      8'h00
`define EDW_RST_SHORT       8'h00
`define EDW_RST_CRC         8'h23

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define EDW_DIAG_CUR        7:4
`define EDW_DIAG_PW         3:0
`define EDW_WD_CODE         7:4
`define EDW_INIT_CODE       3:0
`define EDW_ST_FAILSAFE     0
`define EDW_ST_CRCFAULT     1
`define EDW_ST_INITDONE     2

// ----------------------------------------------------------------------
// Encodings and CRC
// ----------------------------------------------------------------------
`define EDW_CUR_CHANNEL     4'hf
`define EDW_WD_OFF          4'h0
`define EDW_WD_LAST_TIMED   4'hb
`define EDW_CRC_POLY        8'h07
`define EDW_CRC_INIT        8'hff

// ----------------------------------------------------------------------
// Timing: one tick per microsecond
// ----------------------------------------------------------------------
`define EDW_CLK_MHZ         100
`define EDW_TICK_US         1
`define EDW_TICK_CYCLES     (`EDW_TICK_US * `EDW_CLK_MHZ)

`define EDW_PW_0            13'd100
`define EDW_PW_1            13'd20
`define EDW_PW_2            13'd30
`define EDW_PW_3            13'd50
`define EDW_PW_4            13'd80
`define EDW_PW_5            13'd150
`define EDW_PW_6            13'd200
`define EDW_PW_7            13'd300
`define EDW_PW_8            13'd500
`define EDW_PW_9            13'd800
`define EDW_PW_A            13'd1000
`define EDW_PW_B            13'd1200
`define EDW_PW_C            13'd1500
`define EDW_PW_D            13'd2000
`define EDW_PW_E            13'd3000
`define EDW_PW_F            13'd5000

`define EDW_WD_1            19'd200
`define EDW_WD_2            19'd500
`define EDW_WD_3            19'd1000
`define EDW_WD_4            19'd2000
`define EDW_WD_5            19'd5000
`define EDW_WD_6            19'd10000
`define EDW_WD_7            19'd20000
`define EDW_WD_8            19'd50000
`define EDW_WD_9            19'd100000
`define EDW_WD_A            19'd200000
`define EDW_WD_B            19'd500000

`define EDW_IN_0            16'd0
`define EDW_IN_1            16'd50000
`define EDW_IN_2            16'd20000
`define EDW_IN_3            16'd10000
`define EDW_IN_4            16'd5000
`define EDW_IN_5            16'd2000
`define EDW_IN_6            16'd1000
`define EDW_IN_7            16'd500
`define EDW_IN_8            16'd200
`define EDW_IN_9            16'd100
`define EDW_IN_MIN          16'd50

`endif

/* File: rtl/edw_crc8.v */
`timescale 1ns/100ps
`default_nettype none
`include "edw_map.vh"

module edw_crc8 (
    input  wire [31:0] data_in,
    output reg  [7:0]  crc_out
);
    integer   i;
    reg       fb;
    reg [7:0] acc;

    // MSB-first CRC over the stored bytes, unrolled by the loop
    // Accumulates in a local so the output never feeds its own process
    always @* begin
        acc = `EDW_CRC_INIT;
        fb = 1'b0;
        for (i = 31; i >= 0; i = i - 1) begin
            fb = acc[7] ^ data_in[i];
            acc = {acc[6:0], 1'b0} ^ (fb ? `EDW_CRC_POLY : 8'h00);
        end
        crc_out = acc;
    end
endmodule
`default_nettype wire

/* File: test/edw_props.sv */
`timescale 1ns/100ps
`default_nettype none
module edw_props #(
    parameter TICK_DIV = 100
) (
    input wire logic        clk_in,
    input wire logic        reset_n_in,
    input wire logic [7:0]  reg_addr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic        comm_valid_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic        reg_rvalid_out,
    input wire logic [3:0]  work_diag_current_code_out,
    input wire logic [5:0]  diag_current_num_out,
    input wire logic        diag_use_channel_current_out,
    input wire logic [12:0] diag_pulse_us_out,
    input wire logic [18:0] comm_loss_timeout_us_out,
    input wire logic [15:0] init_delay_us_out,
    input wire logic [7:0]  nv_short_threshold_out,
    input wire logic        failsafe_out,
    input wire logic        init_done_out,
    input wire logic        crc_fault_out
);
    // ----------------------------------------
    // Cycles since the last valid host frame
    // ----------------------------------------
    logic [31:0] idle;
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            idle <= 32'h0;
        else if (comm_valid_in)
            idle <= 32'h0;
        else
            idle <= idle + 32'h1;
    end
    default clocking dc @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    read_answer_a: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("read not answered");
    rvalid_cause_a: assert property (reg_rvalid_out |-> $past(reg_rd_in))
        else $error("read valid without read");
    short_read_a: assert property (reg_rd_in && reg_addr_in == 8'hcb
        |=> reg_rdata_out == nv_short_threshold_out) else $error("threshold read differs");
    short_update_a: assert property (reg_wr_in && reg_addr_in == 8'hcb
        |-> ##2 nv_short_threshold_out == $past(reg_wdata_in, 2)) else $error("threshold stale");
    current_formula_a: assert property (work_diag_current_code_out != 4'hf
        |-> diag_current_num_out == {work_diag_current_code_out, 2'b01}) else $error("bad num");
    channel_current_a: assert property (diag_use_channel_current_out
        == (work_diag_current_code_out == 4'hf)) else $error("channel current select wrong");
    direct_failsafe_a: assert property (reg_wr_in && reg_addr_in == 8'hca
        && reg_wdata_in[7:4] >= 4'hc |-> ##[1:3] failsafe_out) else $error("no direct failsafe");
    failsafe_clear_a: assert property (comm_valid_in && comm_loss_timeout_us_out != 19'h0
        |=> !failsafe_out) else $error("failsafe not cleared");
    // Tick phase allows up to two ticks of slack each way
    failsafe_time_a: assert property ($rose(failsafe_out) && comm_loss_timeout_us_out != 0
        |-> idle + 2 * TICK_DIV >= comm_loss_timeout_us_out * TICK_DIV
        && idle <= (comm_loss_timeout_us_out + 2) * TICK_DIV) else $error("timeout length");
    init_stays_a: assert property (init_done_out |=> init_done_out)
        else $error("init done dropped");
endmodule
bind edw_defaults edw_props #(.TICK_DIV(TICK_DIV)) edw_props_i (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .comm_valid_in(comm_valid_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .work_diag_current_code_out(work_diag_current_code_out),
    .diag_current_num_out(diag_current_num_out),
    .diag_use_channel_current_out(diag_use_channel_current_out),
    .diag_pulse_us_out(diag_pulse_us_out), .comm_loss_timeout_us_out(comm_loss_timeout_us_out),
    .init_delay_us_out(init_delay_us_out), .nv_short_threshold_out(nv_short_threshold_out),
    .failsafe_out(failsafe_out), .init_done_out(init_done_out), .crc_fault_out(crc_fault_out)
);
`default_nettype wire

/* File: test/edw_host.sv */
`timescale 1ns/100ps
`default_nettype none
module edw_host (
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    input  wire logic       rvalid_in,
    output var  logic [7:0] addr_out,
    output var  logic [7:0] wdata_out,
    output var  logic       wr_out,
    output var  logic       rd_out,
    output var  logic       valid_out
);
    // ----------------------------------------
    // Host side, entered just after a rising edge
    // ----------------------------------------
    initial {addr_out, wdata_out, wr_out, rd_out, valid_out} = '0;
    // Released lines show the inverse so stale values cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_out = a;
        wdata_out = d;
        wr_out = 1'b1;
        @(posedge clk_in);
        #1 wr_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~d;
        // Idle edge so a following call never re-raises the strobe in this step
        @(posedge clk_in);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        addr_out = a;
        rd_out = 1'b1;
        @(posedge clk_in);
        #1 rd_out = 1'b0;
        addr_out = ~a;
        for (n = 0; n < 8 && rvalid_in !== 1'b1; n++) begin
            @(posedge clk_in);
            #1;
        end
        d = rdata_in;
        @(posedge clk_in);
        #1;
    endtask
    // Silence between pings models a lost or absent host
    task automatic ping();
        valid_out = 1'b1;
        @(posedge clk_in);
        #1 valid_out = 1'b0;
        @(posedge clk_in);
        #1;
    endtask
endmodule
`default_nettype wire

/* File: test/tb_eeprom_diag_watchdog_defaults.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_eeprom_diag_watchdog_defaults;
    localparam int TD = 2;
    logic        clk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [7:0]  addr, wd, rdat, thr, b, t, r, rv;
    logic        wr, rd, rvl, cv, fs, idn, cfl, uch;
    logic [3:0]  wc;
    logic [5:0]  num;
    logic [12:0] pw;
    logic [18:0] to;
    logic [15:0] ini;
    int n_errors = 0, comparisons = 0, seed = 63, cyc = 0, n;
    int pw_t[16] = '{100,20,30,50,80,150,200,300,500,800,1000,1200,1500,2000,3000,5000};
    int wd_t[12] = '{0,200,500,1000,2000,5000,10000,20000,50000,100000,200000,500000};
    int in_t[16] = '{0,50000,20000,10000,5000,2000,1000,500,200,100,50,50,50,50,50,50};
    always #5 clk_in = ~clk_in;
    edw_defaults #(.TICK_DIV(TD)) edw_defaults_i (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(addr),
        .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .comm_valid_in(cv),
        .reg_rdata_out(rdat), .reg_rvalid_out(rvl), .work_diag_current_code_out(wc),
        .diag_current_num_out(num), .diag_use_channel_current_out(uch),
        .diag_pulse_us_out(pw), .comm_loss_timeout_us_out(to), .init_delay_us_out(ini),
        .nv_short_threshold_out(thr), .failsafe_out(fs), .init_done_out(idn),
        .crc_fault_out(cfl)
    );
    edw_host edw_host_i (
        .clk_in(clk_in), .rdata_in(rdat), .rvalid_in(rvl), .addr_out(addr),
        .wdata_out(wd), .wr_out(wr), .rd_out(rd), .valid_out(cv)
    );
    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic tick(int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask
    task automatic rdr(logic [7:0] a, logic [7:0] e);
        edw_host_i.rd(a, rv);
        chk("read data", rv, e);
    endtask
    task automatic rst_vals();
        rdr(8'hc9, 8'h00);
        rdr(8'hca, 8'h00);
        rdr(8'hcb, 8'h00);
        rdr(8'hcf, 8'h23);
    endtask
    function automatic logic [7:0] crc8(logic [31:0] d);
        logic [7:0] c;
        c = 8'hff;
        for (int i = 31; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            conclude();
        end
    end
    initial begin
        repeat (10) @(posedge clk_in);
        #1 reset_n_in = 1'b1;
        tick(1);
        rst_vals();
        chk("crc fault", cfl, 1'b1);
        chk("init done", idn, 1'b1);
        $display("reset test done");
        r = 8'($random(seed));
        for (int i = 0; i < 16; i++) begin
            b = {i[3:0], i[3:0] + r[3:0]};
            edw_host_i.wr(8'hc9, b);
            tick(2);
            chk("current code", wc, b[7:4]);
            chk("channel current", uch, b[7:4] == 4'hf);
            if (b[7:4] != 4'hf)
                chk("current num", num, b[7:4] * 4 + 1);
            chk("pulse width", pw, pw_t[b[3:0]]);
            rdr(8'hc9, b);
        end
        t = 8'($random(seed));
        edw_host_i.wr(8'hcb, t);
        tick(2);
        chk("threshold", thr, t);
        rdr(8'hcb, t);
        for (int i = 0; i < 16; i++) begin
            edw_host_i.wr(8'hca, {4'h0, i[3:0]});
            tick(2);
            chk("init delay", ini, in_t[i]);
        end
        $display("decode test done");
        for (int i = 1; i < 12; i++) begin
            edw_host_i.ping();
            edw_host_i.wr(8'hca, {i[3:0], 4'h0});
            tick(2);
            chk("timeout", to, wd_t[i]);
        end
        edw_host_i.wr(8'hca, 8'h10);
        edw_host_i.ping();
        for (n = 0; n < 2000 && fs !== 1'b1; n++)
            tick(1);
        chk("timeout hit", n >= 198 * TD && n <= 202 * TD, 1'b1);
        edw_host_i.ping();
        chk("failsafe cleared", fs, 1'b0);
        edw_host_i.wr(8'hca, 8'h00);
        edw_host_i.ping();
        tick(1000);
        chk("watchdog off", fs, 1'b0);
        for (int i = 12; i < 16; i++) begin
            edw_host_i.wr(8'hca, 8'h00);
            edw_host_i.wr(8'hca, {i[3:0], 4'h0});
            tick(2);
            edw_host_i.ping();
            chk("direct failsafe", fs, 1'b1);
            chk("zero timeout", to, 19'h0);
        end
        edw_host_i.wr(8'hca, 8'h00);
        edw_host_i.ping();
        $display("watchdog test done");
        edw_host_i.wr(8'hcf, crc8({b, 8'h00, t, 8'h00}));
        tick(3);
        chk("crc fault", cfl, 1'b0);
        edw_host_i.wr(8'hd0, 8'hff);
        rdr(8'hd0, 8'h04);
        rdr(8'hcc, 8'h00);
        edw_host_i.wr(8'hcf, ~crc8({b, 8'h00, t, 8'h00}));
        tick(3);
        chk("crc fault", cfl, 1'b1);
        reset_n_in = 1'b0;
        tick(3);
        reset_n_in = 1'b1;
        tick(1);
        rst_vals();
        $display("crc and reset test done");
        conclude();
    end
endmodule
`default_nettype wire
